// [verilog/fas_host.v]
// Host controller that reads identification codes from a parallel NOR flash
`timescale 1ns/1ps
`include "fas_defs.vh"
module fas_host (
	// Clock and reset
	input wire core_clk_in,
	input wire rst_n_in,
	// User request
	input wire req_in,
	input wire use_hv_in,
	input wire [`FAS_CODE_W-1:0] code_sel_in,
	input wire [`FAS_SECT_W-1:0] sector_in,
	// User answer
	output reg busy_out,
	output reg done_out,
	output reg [7:0] id_code_out,
	output reg prot_out,
	// Flash pins
	output reg [`FAS_ADDR_W-1:0] flash_addr_out,
	output reg [`FAS_DATA_W-1:0] flash_dq_out,
	output reg flash_dq_oe_out,
	input wire [`FAS_DATA_W-1:0] flash_dq_in,
	output reg flash_ce_n_out,
	output reg flash_oe_n_out,
	output reg flash_we_n_out,
	output reg high_voltage_id_level_out
);
	// ==========================================================
	// States
	// ==========================================================
	localparam ST_IDLE = 3'h0;
	localparam ST_WADDR = 3'h1;
	localparam ST_WPULSE = 3'h2;
	localparam ST_WHOLD = 3'h3;
	localparam ST_READ = 3'h4;
	localparam ST_DONE = 3'h5;

	reg [2:0] state_ff;
	reg [`FAS_CNT_W-1:0] cnt_ff; // Wait counter
	reg [1:0] step_ff; // Command write index
	reg exit_ff; // Writing the exit command
	reg hv_ff; // Latched method
	reg [`FAS_CODE_W-1:0] code_ff;
	reg [`FAS_SECT_W-1:0] sect_ff;
	wire [`FAS_DATA_W-1:0] dq_sync; // Data after two flops

	// Data pins come from the device domain
	fas_sync #(.W(`FAS_DATA_W)) u_sync (
		.core_clk_in(core_clk_in),
		.rst_n_in(rst_n_in),
		.async_in(flash_dq_in),
		.sync_out(dq_sync)
	);

	// ==========================================================
	// Address for a read: sector on high bits, code on low
	// ==========================================================
	function [`FAS_ADDR_W-1:0] read_addr;
		input [`FAS_CODE_W-1:0] c;
		input [`FAS_SECT_W-1:0] s;
		reg [`FAS_ADDR_W-1:0] a;
		begin
			a = {`FAS_ADDR_W{1'b0}}; // Unused bits held low, device ignores them
			a[`FAS_SECT_LSB +: `FAS_SECT_W] = s;
			case (c)
				// Bits 6,3,2,1,0 pattern
				`FAS_SEL_MFR: a[6:0] = 7'h00;
				`FAS_SEL_DEV1: a[6:0] = 7'h01;
				`FAS_SEL_DEV2: a[6:0] = 7'h0E;
				`FAS_SEL_DEV3: a[6:0] = 7'h0F;
				`FAS_SEL_PROT: a[6:0] = 7'h02;
				`FAS_SEL_SECSI: a[6:0] = 7'h03;
				default: a[6:0] = 7'h00;
			endcase
			read_addr = a;
		end
	endfunction

	// Command write address and data per step
	reg [`FAS_ADDR_W-1:0] cmd_addr;
	reg [`FAS_DATA_W-1:0] cmd_data;
	always @* begin
		case (step_ff)
			2'h0: begin
				cmd_addr = `FAS_UNLOCK_ADDR1;
				cmd_data = exit_ff ? `FAS_EXIT_CMD : `FAS_UNLOCK_DATA1;
			end
			2'h1: begin
				cmd_addr = `FAS_UNLOCK_ADDR2;
				cmd_data = `FAS_UNLOCK_DATA2;
			end
			default: begin
				cmd_addr = `FAS_UNLOCK_ADDR1;
				cmd_data = `FAS_ID_CMD;
			end
		endcase
	end

	// ==========================================================
	// Main sequencer
	// ==========================================================
	always @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			state_ff <= ST_IDLE;
			cnt_ff <= {`FAS_CNT_W{1'b0}};
			step_ff <= 2'h0;
			exit_ff <= 1'b0;
			hv_ff <= 1'b0;
			code_ff <= {`FAS_CODE_W{1'b0}};
			sect_ff <= {`FAS_SECT_W{1'b0}};
			busy_out <= 1'b0;
			done_out <= 1'b0;
			id_code_out <= 8'h00;
			prot_out <= 1'b0;
			flash_addr_out <= {`FAS_ADDR_W{1'b0}};
			flash_dq_out <= {`FAS_DATA_W{1'b0}};
			flash_dq_oe_out <= 1'b0;
			flash_ce_n_out <= 1'b1;
			flash_oe_n_out <= 1'b1;
			flash_we_n_out <= 1'b1;
			high_voltage_id_level_out <= 1'b0;
		end else begin
			done_out <= 1'b0;
			case (state_ff)
				// Wait for a request
				ST_IDLE: begin
					if (req_in) begin
						busy_out <= 1'b1;
						hv_ff <= use_hv_in;
						code_ff <= code_sel_in;
						sect_ff <= sector_in;
						cnt_ff <= {`FAS_CNT_W{1'b0}};
						step_ff <= 2'h0;
						exit_ff <= 1'b0;
						if (use_hv_in) begin
							// Hold high voltage for the whole read
							high_voltage_id_level_out <= 1'b1;
							flash_addr_out <= read_addr(code_sel_in, sector_in);
							flash_ce_n_out <= 1'b0;
							flash_oe_n_out <= 1'b0;
							state_ff <= ST_READ;
						end else begin
							// In-system path uses logic levels only
							high_voltage_id_level_out <= 1'b0;
							state_ff <= ST_WADDR;
						end
					end
				end
				// Set up address and data of a command write
				ST_WADDR: begin
					flash_addr_out <= cmd_addr;
					flash_dq_out <= cmd_data;
					flash_dq_oe_out <= 1'b1;
					flash_ce_n_out <= 1'b0;
					cnt_ff <= {`FAS_CNT_W{1'b0}};
					state_ff <= ST_WPULSE;
				end
				// Write strobe low for the minimum width
				ST_WPULSE: begin
					flash_we_n_out <= 1'b0;
					if (cnt_ff == `FAS_WE_CYC) begin
						flash_we_n_out <= 1'b1;
						cnt_ff <= {`FAS_CNT_W{1'b0}};
						state_ff <= ST_WHOLD;
					end else begin
						cnt_ff <= cnt_ff + 1'b1;
					end
				end
				// Release bus, pick next write, the read or done
				ST_WHOLD: begin
					flash_dq_oe_out <= 1'b0;
					flash_ce_n_out <= 1'b1;
					if (exit_ff) begin
						// Exit command written, device back in array mode
						exit_ff <= 1'b0;
						state_ff <= ST_DONE;
					end else if (step_ff == 2'h2) begin
						// Chip enable stays low from the last command write into the read.
						// The device then sees no gap that could drop it out of id mode.
						flash_addr_out <= read_addr(code_ff, sect_ff);
						flash_ce_n_out <= 1'b0;
						flash_oe_n_out <= 1'b0;
						state_ff <= ST_READ;
					end else begin
						step_ff <= step_ff + 2'h1;
						state_ff <= ST_WADDR;
					end
				end
				// Wait access time, then take the low byte
				ST_READ: begin
					if (cnt_ff == `FAS_ACCESS_CYC + 2) begin
						// Extra two cycles cover the input synchroniser
						// A slower part needs a larger access count, not a faster clock
						id_code_out <= dq_sync[7:0];
						prot_out <= dq_sync[0];
						flash_oe_n_out <= 1'b1;
						flash_ce_n_out <= 1'b1;
						high_voltage_id_level_out <= 1'b0;
						cnt_ff <= {`FAS_CNT_W{1'b0}};
						if (hv_ff) begin
							state_ff <= ST_DONE;
						end else begin
							// Leave command mode with the exit command
							exit_ff <= 1'b1;
							step_ff <= 2'h0;
							state_ff <= ST_WADDR;
						end
					end else begin
						cnt_ff <= cnt_ff + 1'b1;
					end
				end
				// Report completion
				// Busy falls with the done pulse, so a new request may follow at once
				ST_DONE: begin
					busy_out <= 1'b0;
					done_out <= 1'b1;
					state_ff <= ST_IDLE;
				end
				default: state_ff <= ST_IDLE;
			endcase
		end
	end
endmodule // fas_host

// [verilog/fas_defs.vh]
// Constants for the flash identification and sector-decode host controller
`ifndef FAS_DEFS_VH
`define FAS_DEFS_VH

// ==========================================================
// Address and data layout
// ==========================================================
`define FAS_ADDR_W 22
`define FAS_SECT_W 7
`define FAS_SECT_LSB 15
`define FAS_DATA_W 16
`define FAS_CODE_W 3

// ==========================================================
// Code-select patterns on A6,A3,A2,A1,A0 (index code)
// ==========================================================
`define FAS_SEL_MFR 3'h0
`define FAS_SEL_DEV1 3'h1
`define FAS_SEL_DEV2 3'h2
`define FAS_SEL_DEV3 3'h3
`define FAS_SEL_PROT 3'h4
`define FAS_SEL_SECSI 3'h5

// ==========================================================
// Command sequence (neutral values, real encoding not given)
// ==========================================================
`define FAS_UNLOCK_ADDR1 22'h000555
`define FAS_UNLOCK_ADDR2 22'h0002AA
`define FAS_UNLOCK_DATA1 16'h00AA
`define FAS_UNLOCK_DATA2 16'h0055
`define FAS_ID_CMD 16'h0090
`define FAS_EXIT_CMD 16'h00F0

// ==========================================================
// Timing
// ==========================================================
`define FAS_CLK_NS 25
`define FAS_ACCESS_NS 90
`define FAS_ACCESS_CYC ((`FAS_ACCESS_NS + `FAS_CLK_NS - 1) / `FAS_CLK_NS)
`define FAS_WE_NS 35
`define FAS_WE_CYC ((`FAS_WE_NS + `FAS_CLK_NS - 1) / `FAS_CLK_NS)
`define FAS_CNT_W 4

`endif

// [verilog/fas_sync.v]
// Two-flop synchroniser bank for device data pins
`timescale 1ns/1ps
module fas_sync #(
	parameter W = 16
) (
	// Clock and reset
	input wire core_clk_in,
	input wire rst_n_in,
	// Data
	input wire [W-1:0] async_in,
	output wire [W-1:0] sync_out
);
	// First and second stage per bit
	reg [W-1:0] meta_ff;
	reg [W-1:0] sync_ff;

	// ==========================================================
	// Per-bit double flop
	// ==========================================================
	genvar gi;
	generate
		for (gi = 0; gi < W; gi = gi + 1) begin : g_bit
			// Stage one is read only by stage two
			always @(posedge core_clk_in) begin
				if (!rst_n_in) begin
					meta_ff[gi] <= 1'b0;
					sync_ff[gi] <= 1'b0;
				end else begin
					meta_ff[gi] <= async_in[gi];
					sync_ff[gi] <= meta_ff[gi];
				end
			end
		end
	endgenerate

	assign sync_out = sync_ff;
endmodule // fas_sync

// [bench/fas_host_asserts.sv]
// Assertion checker for the identification host
`timescale 1ns/1ps
`include "fas_defs.vh"
// ========
// Checker
module fas_host_asserts (
	input wire core_clk_in,
	input wire rst_n_in,
	input wire req_in,
	input wire use_hv_in,
	input wire [`FAS_CODE_W-1:0] code_sel_in,
	input wire [`FAS_SECT_W-1:0] sector_in,
	input wire busy_out,
	input wire done_out,
	input wire [7:0] id_code_out,
	input wire [`FAS_ADDR_W-1:0] flash_addr_out,
	input wire flash_dq_oe_out,
	input wire flash_ce_n_out,
	input wire flash_oe_n_out,
	input wire flash_we_n_out,
	input wire high_voltage_id_level_out
);
	reg [2:0] code_ff; // Code of the request in flight
	reg [6:0] sec_ff; // Sector of the request in flight
	reg hv_ff; // Method of the request in flight
	reg [6:0] pat; // Low address pattern the code needs
	wire take = req_in && !busy_out; // Request accepted, busy is low only in idle
	// Capture the request so later pins can be tied to it
	always @(posedge core_clk_in) begin
		if (take) begin
			code_ff <= code_sel_in;
			sec_ff <= sector_in;
			hv_ff <= use_hv_in;
		end
	end
	// Pattern table for the code select bits
	always @* begin
		case (code_ff)
			3'h0: pat = 7'h00;
			3'h1: pat = 7'h01;
			3'h2: pat = 7'h0E;
			3'h3: pat = 7'h0F;
			3'h4: pat = 7'h02;
			default: pat = 7'h03;
		endcase
	end
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);
	hv_read_a: assert property (high_voltage_id_level_out |-> !flash_ce_n_out && !flash_oe_n_out)
		else $error("hv level outside read");
	hv_len_a: assert property ($rose(high_voltage_id_level_out) |->
		high_voltage_id_level_out[*7] ##1 !high_voltage_id_level_out)
		else $error("hv level length wrong");
	addr_hold_a: assert property (!flash_oe_n_out && $past(!flash_oe_n_out) |-> $stable(flash_addr_out))
		else $error("address moved in read");
	code_pat_a: assert property (!flash_oe_n_out |-> flash_addr_out[14:0] == {8'h00, pat})
		else $error("code pattern wrong");
	sect_addr_a: assert property (!flash_oe_n_out && code_ff == 3'h4 |-> flash_addr_out[21:15] == sec_ff)
		else $error("sector bits wrong");
	cmd_nohv_a: assert property (!flash_we_n_out || (busy_out && !hv_ff) |-> !high_voltage_id_level_out)
		else $error("hv level in command path");
	write_bus_a: assert property (!flash_we_n_out |-> flash_dq_oe_out && flash_oe_n_out && !flash_ce_n_out)
		else $error("write cycle malformed");
	hv_done_a: assert property (take && use_hv_in |-> ##[8:9] done_out)
		else $error("hv read late");
	cmd_done_a: assert property (take && !use_hv_in |-> ##[20:40] done_out)
		else $error("command read late");
	id_hold_a: assert property ($changed(id_code_out) |-> busy_out)
		else $error("code changed while idle");
endmodule // fas_host_asserts

bind fas_host fas_host_asserts chk_u (.core_clk_in, .rst_n_in, .req_in, .use_hv_in, .code_sel_in,
	.sector_in, .busy_out, .done_out, .id_code_out, .flash_addr_out, .flash_dq_oe_out,
	.flash_ce_n_out, .flash_oe_n_out, .flash_we_n_out, .high_voltage_id_level_out);

// [bench/fas_flash_model.sv]
// Behavioural flash device answering identification reads
`timescale 1ns/1ps
`include "fas_defs.vh"
// ========
// Device model
module fas_flash_model #(
	// Identifier codes, values arbitrary
	parameter [7:0] C0 = 8'h3C, C1 = 8'h41, C2 = 8'h52, C3 = 8'h63, C5 = 8'h74
) (
	input wire [21:0] addr_in,
	input wire [15:0] dq_in,
	input wire ce_n_in,
	input wire oe_n_in,
	input wire we_n_in,
	input wire hv_in,
	output logic [15:0] dq_out = 16'h0000
);
	logic id_mode = 1'b0; // Entered by command
	logic [1:0] step = 2'h0; // Unlock progress
	logic [7:0] b; // Byte for the current address
	wire [37:0] w = {addr_in, dq_in}; // Write cycle seen
	// Commands latch on the rising write strobe; any slip restarts the unlock
	always @(posedge we_n_in) if (!ce_n_in) begin
		step <= 2'h0;
		if (dq_in == `FAS_EXIT_CMD)
			id_mode <= 1'b0;
		else if (step == 2'h0 && w == {`FAS_UNLOCK_ADDR1, `FAS_UNLOCK_DATA1})
			step <= 2'h1;
		else if (step == 2'h1 && w == {`FAS_UNLOCK_ADDR2, `FAS_UNLOCK_DATA2})
			step <= 2'h2;
		else if (step == 2'h2 && w == {`FAS_UNLOCK_ADDR1, `FAS_ID_CMD})
			id_mode <= 1'b1;
	end
	// Only A6..A0 and sector bits A21 and A15 decode; the rest is ignored
	always @* begin
		case (addr_in[6:0])
			7'h00: b = C0;
			7'h01: b = C1;
			7'h0E: b = C2;
			7'h0F: b = C3;
			7'h02: b = {7'h00, addr_in[21] ^ addr_in[15]};
			7'h03: b = C5;
			default: b = 8'hEE;
		endcase
		if (!hv_in && !id_mode) b = 8'hEE;
	end
	// Released bus shows the inverse of the last value, never a stale copy
	always @(ce_n_in, oe_n_in, b) dq_out = (!ce_n_in && !oe_n_in) ? {~b, b} : ~dq_out;
endmodule // fas_flash_model

// [bench/test_flash_autoselect_sector_decode.sv]
// Testbench for the identification host controller
`timescale 1ns/1ps
`include "fas_defs.vh"
// ========
// Bench top
module test_flash_autoselect_sector_decode;
	localparam [7:0] C0 = 8'h3C, C1 = 8'h41, C2 = 8'h52, C3 = 8'h63, C5 = 8'h74; // Arbitrary
	// Edges from the taking edge to done: read window plus done state
	localparam int HV_CYC = `FAS_ACCESS_CYC + 4;
	// Four command writes of address, pulse and hold, plus the read window and done state
	localparam int CMD_CYC = 4 * (`FAS_WE_CYC + 3) + `FAS_ACCESS_CYC + 4;
	logic clk = 0, rst_n = 0, req = 0, hv = 0;
	logic [2:0] code = 3'h0;
	logic [6:0] sec = 7'h00;
	wire busy, done, prot, oe, ce_n, oe_n, we_n, hvl;
	wire [7:0] id;
	wire [21:0] addr;
	wire [15:0] dq_o, dq_m;
	wire [15:0] dq_i = oe ? dq_o : dq_m; // Wire level seen by the host
	int failures = 0, checks = 0;
	always #12.5 clk = ~clk;
	fas_host dut_u (.core_clk_in(clk), .rst_n_in(rst_n), .req_in(req), .use_hv_in(hv),
		.code_sel_in(code), .sector_in(sec), .busy_out(busy), .done_out(done),
		.id_code_out(id), .prot_out(prot), .flash_addr_out(addr), .flash_dq_out(dq_o),
		.flash_dq_oe_out(oe), .flash_dq_in(dq_i), .flash_ce_n_out(ce_n),
		.flash_oe_n_out(oe_n), .flash_we_n_out(we_n), .high_voltage_id_level_out(hvl));
	fas_flash_model #(.C0(C0), .C1(C1), .C2(C2), .C3(C3), .C5(C5)) dev_u (.addr_in(addr),
		.dq_in(dq_o), .ce_n_in(ce_n), .oe_n_in(oe_n), .we_n_in(we_n), .hv_in(hvl), .dq_out(dq_m));
	task automatic stop_test;
		$display("checks=%0d failures=%0d", checks, failures);
		if (failures == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic ok);
		checks++;
		if (!ok) begin
			failures++;
			$display("BAD %0t read result wrong", $time);
		end
	endtask
	function automatic logic [7:0] exp_id(input logic [2:0] c, input logic [6:0] s);
		case (c)
			3'h0: return C0;
			3'h1: return C1;
			3'h2: return C2;
			3'h3: return C3;
			3'h4: return {7'h00, s[6] ^ s[0]};
			default: return C5;
		endcase
	endfunction
	// One read; req stays up for hold edges, extra ones land while busy
	task automatic rd(input logic h, input logic [2:0] c, input logic [6:0] s, input int hold);
		int n = 0;
		@(posedge clk);
		req <= 1'b1;
		hv <= h;
		code <= c;
		sec <= s;
		repeat (hold) @(posedge clk);
		req <= 1'b0;
		while (done !== 1'b1) begin
			@(posedge clk);
			#1;
			n++;
			if (n > 100) begin
				failures++;
				$display("BAD %0t no completion from the controller", $time);
				stop_test;
			end
		end
		chk(id === exp_id(c, s));
		if (c == 3'h4) chk(prot === (s[6] ^ s[0]));
		chk(n + hold - 1 == (h ? HV_CYC : CMD_CYC));
	endtask
	task automatic t_hv;
		for (int c = 0; c < 6; c++) rd(1'b1, c[2:0], 7'h2A, 1);
		$display("t_hv done");
	endtask
	task automatic t_sect;
		logic [6:0] s [4] = '{7'h00, 7'h01, 7'h40, 7'h7F};
		foreach (s[i]) rd(1'b1, 3'h4, s[i], 1);
		$display("t_sect done");
	endtask
	task automatic t_cmd;
		for (int c = 0; c < 6; c++) rd(1'b0, c[2:0], 7'h55, 1);
		$display("t_cmd done");
	endtask
	// Request held for several edges while busy must not start a second read
	task automatic t_busy;
		rd(1'b1, 3'h1, 7'h11, 4);
		rd(1'b0, 3'h4, 7'h41, 6);
		@(posedge clk);
		#1;
		chk(busy === 1'b0);
		$display("t_busy done");
	endtask
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		t_hv;
		t_sect;
		t_cmd;
		t_busy;
		stop_test;
	end
endmodule // test_flash_autoselect_sector_decode
